// ---- core/spdif_irq_cfg.svh ----
// register map, field positions and mask reset value of the status interrupt block
`ifndef SPDIF_IRQ_CFG_SVH
`define SPDIF_IRQ_CFG_SVH
`define ADDR_IRQ_MASK 7'h25
`define ADDR_IRQ_CAUSE 7'h2b
`define ADDR_FLAG_LEVELS 7'h31
`define MASK_RESET 9'h000
// synchronised flag vector positions
`define FL_UNLOCK 0
`define FL_INVALID 1
`define FL_BLKUPD 2
`define FL_FRMERR 3
`define FL_NONPCM_CS 4
`define FL_BURST 5
`define FL_COPYFREE 6
`define FL_PREEMPH 7
`define FL_RATE0 8
`define FL_RATE1 9
// cause register bits
`define CB_LOCK 0
`define CB_INVALID 1
`define CB_BLKUPD 2
`define CB_FRMERR 3
`define CB_NONPCM 4
`define CB_COPY 5
`define CB_PREEMPH 6
`define CB_RATE 7
// mask register bits
`define MB_LOCK 0
`define MB_INVALID 1
`define MB_BLKUPD 2
`define MB_FRMERR 3
`define MB_NONPCM_CS 4
`define MB_BURST 5
`define MB_COPY 6
`define MB_PREEMPH 7
`define MB_RATE 8
`endif

// ---- core/spdif_irq_pkg.sv ----
// types shared by the status interrupt block
package spdif_irq_pkg;
  typedef logic [9:0] flag_vec_t;
  typedef logic [8:0] mask_t;
  typedef logic [7:0] cause_t;
  typedef logic [6:0] reg_addr_t;
endpackage : spdif_irq_pkg

// ---- core/flag_edge_detect.sv ----
// synchroniser and edge detector for the receiver status flags
`timescale 1ns/1ps
`default_nettype none
module flag_edge_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire spdif_irq_pkg::flag_vec_t flags_async,
  output spdif_irq_pkg::flag_vec_t level,
  output spdif_irq_pkg::flag_vec_t rise,
  output spdif_irq_pkg::flag_vec_t change
);
  typedef struct packed {
    spdif_irq_pkg::flag_vec_t meta;
    spdif_irq_pkg::flag_vec_t sync;
    spdif_irq_pkg::flag_vec_t prev;
  } edge_state_t;

  edge_state_t st_ff;
  edge_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = flags_async;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  // prev starts at zero, so a flag already high out of reset counts as an edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.sync;
  assign rise = st_ff.sync & ~st_ff.prev;
  assign change = st_ff.sync ^ st_ff.prev;
endmodule : flag_edge_detect
`default_nettype wire

// ---- core/spdif_rx_status_interrupt.sv ----
// receiver status interrupt: mask, cause latch, flag level readback
`timescale 1ns/1ps
`include "spdif_irq_cfg.svh"
`default_nettype none
module spdif_rx_status_interrupt (
  input wire logic clk,
  input wire logic nrst,
  input wire logic lock_lost_flag,
  input wire logic invalid_flag,
  input wire logic frame_error_flag,
  input wire logic chan_status_block_update,
  input wire logic nonpcm_cs_flag,
  input wire logic burst_sync_flag,
  input wire logic copyright_free_flag,
  input wire logic preemphasis_flag,
  input wire logic [1:0] recovered_rate_code,
  input wire spdif_irq_pkg::reg_addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic [8:0] reg_wdata,
  input wire logic reg_rd,
  output logic [8:0] reg_rdata,
  output logic status_irq_low
);
  typedef struct packed {
    spdif_irq_pkg::mask_t mask;
    spdif_irq_pkg::cause_t cause;
    logic [8:0] rdata;
    logic irq_low;
  } irq_state_t;

  function automatic logic hit(input spdif_irq_pkg::reg_addr_t a,
                               input spdif_irq_pkg::reg_addr_t target);
    hit = (a == target);
  endfunction : hit

  logic rst_meta_ff;
  logic rst_n_ff;
  irq_state_t st_ff;
  irq_state_t nxt_st;
  spdif_irq_pkg::flag_vec_t flags_in;
  spdif_irq_pkg::flag_vec_t lvl;
  spdif_irq_pkg::flag_vec_t rise;
  spdif_irq_pkg::flag_vec_t chg;
  spdif_irq_pkg::cause_t ev;
  spdif_irq_pkg::cause_t held;
  logic [6:0] levels;
  logic rd_cause;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // flags come from the recovery clock domain, hence the synchroniser
  assign flags_in = {recovered_rate_code, preemphasis_flag, copyright_free_flag,
                     burst_sync_flag, nonpcm_cs_flag, frame_error_flag,
                     chan_status_block_update, invalid_flag, lock_lost_flag};

  flag_edge_detect u_edges (
    .clk(clk),
    .rst_n(rst_n_ff),
    .flags_async(flags_in),
    .level(lvl),
    .rise(rise),
    .change(chg)
  );

  // raw levels straight through, mask never touches them
  assign levels = {lvl[`FL_UNLOCK], lvl[`FL_RATE1], lvl[`FL_RATE0], lvl[`FL_PREEMPH],
                   lvl[`FL_COPYFREE], lvl[`FL_BURST], lvl[`FL_NONPCM_CS]};

  assign rd_cause = reg_rd && hit(reg_addr, `ADDR_IRQ_CAUSE);

  always_comb
  begin
    ev = '0;
    held = '0;
    ev[`CB_LOCK] = chg[`FL_UNLOCK] & ~st_ff.mask[`MB_LOCK];
    ev[`CB_INVALID] = rise[`FL_INVALID] & ~st_ff.mask[`MB_INVALID];
    ev[`CB_BLKUPD] = rise[`FL_BLKUPD] & ~st_ff.mask[`MB_BLKUPD];
    ev[`CB_FRMERR] = rise[`FL_FRMERR] & ~st_ff.mask[`MB_FRMERR];
    ev[`CB_NONPCM] = (chg[`FL_NONPCM_CS] & ~st_ff.mask[`MB_NONPCM_CS])
                   | (chg[`FL_BURST] & ~st_ff.mask[`MB_BURST]);
    ev[`CB_COPY] = chg[`FL_COPYFREE] & ~st_ff.mask[`MB_COPY];
    ev[`CB_PREEMPH] = chg[`FL_PREEMPH] & ~st_ff.mask[`MB_PREEMPH];
    ev[`CB_RATE] = (chg[`FL_RATE0] | chg[`FL_RATE1]) & ~st_ff.mask[`MB_RATE];
    held[`CB_INVALID] = lvl[`FL_INVALID] & ~st_ff.mask[`MB_INVALID];
    held[`CB_BLKUPD] = lvl[`FL_BLKUPD] & ~st_ff.mask[`MB_BLKUPD];
    held[`CB_FRMERR] = lvl[`FL_FRMERR] & ~st_ff.mask[`MB_FRMERR];

    nxt_st = st_ff;
    if (reg_wr && hit(reg_addr, `ADDR_IRQ_MASK))
    begin
      nxt_st.mask = reg_wdata;
    end
    // set wins over the read clear so no event is lost
    if (rd_cause)
    begin
      nxt_st.cause = ev | held;
    end
    else
    begin
      nxt_st.cause = st_ff.cause | ev;
    end
    nxt_st.irq_low = ~(|nxt_st.cause);
    if (reg_rd)
    begin
      if (rd_cause)
      begin
        nxt_st.rdata = {1'b0, st_ff.cause};
      end
      else if (hit(reg_addr, `ADDR_IRQ_MASK))
      begin
        nxt_st.rdata = st_ff.mask;
      end
      else if (hit(reg_addr, `ADDR_FLAG_LEVELS))
      begin
        nxt_st.rdata = {2'b00, levels};
      end
      else
      begin
        nxt_st.rdata = 9'h000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      st_ff <= '{mask: `MASK_RESET, cause: 8'h00, rdata: 9'h000, irq_low: 1'b1};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign status_irq_low = st_ff.irq_low;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_ff);

  property p_irq_follows_cause;
    (|ev) |=> !status_irq_low && ((st_ff.cause & $past(ev)) == $past(ev));
  endproperty
  a_irq_follows_cause: assert property (p_irq_follows_cause)
    else $error("unmasked event not latched or interrupt not asserted");

  property p_invalid_fall_quiet;
    ($fell(lvl[`FL_INVALID]) && !st_ff.cause[`CB_INVALID] && !rd_cause) |=> !st_ff.cause[`CB_INVALID];
  endproperty
  a_invalid_fall_quiet: assert property (p_invalid_fall_quiet)
    else $error("invalid falling edge raised a cause");

  property p_lock_fall_sets;
    ($fell(lvl[`FL_UNLOCK]) && !st_ff.mask[`MB_LOCK]) |=> st_ff.cause[`CB_LOCK] && !status_irq_low;
  endproperty
  a_lock_fall_sets: assert property (p_lock_fall_sets)
    else $error("lock change did not set its cause");

  property p_irq_holds;
    (!status_irq_low && !rd_cause) |=> !status_irq_low;
  endproperty
  a_irq_holds: assert property (p_irq_holds)
    else $error("interrupt released without a cause read");

  property p_invalid_relatch;
    (rd_cause && lvl[`FL_INVALID] && !st_ff.mask[`MB_INVALID]) |=> st_ff.cause[`CB_INVALID] && !status_irq_low;
  endproperty
  a_invalid_relatch: assert property (p_invalid_relatch)
    else $error("invalid still high but interrupt dropped after read");

  property p_cause_readback;
    rd_cause |=> reg_rdata == {1'b0, $past(st_ff.cause)};
  endproperty
  a_cause_readback: assert property (p_cause_readback)
    else $error("cause readback mismatch");

  property p_masked_blkupd;
    (st_ff.mask[`MB_BLKUPD] && rd_cause && !reg_wr) |=> !st_ff.cause[`CB_BLKUPD];
  endproperty
  a_masked_blkupd: assert property (p_masked_blkupd)
    else $error("masked source set its cause");

  property p_levels_readback;
    (reg_rd && hit(reg_addr, `ADDR_FLAG_LEVELS)) |=> reg_rdata[6] == $past(lvl[`FL_UNLOCK]) && reg_rdata[5:4] == $past(lvl[`FL_RATE1:`FL_RATE0]);
  endproperty
  a_levels_readback: assert property (p_levels_readback)
    else $error("status register does not show flag levels");

  property p_mask_write;
    (reg_wr && hit(reg_addr, `ADDR_IRQ_MASK)) |=> st_ff.mask == $past(reg_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_burst_change_sets;
    ($changed(lvl[`FL_BURST]) && !st_ff.mask[`MB_BURST]) |=> st_ff.cause[`CB_NONPCM];
  endproperty
  a_burst_change_sets: assert property (p_burst_change_sets)
    else $error("burst sync change did not set nonpcm cause");

  c_irq_raised: cover property ($fell(status_irq_low));
  c_irq_cleared: cover property (rd_cause ##1 status_irq_low);
  c_relatch: cover property (rd_cause && held != 8'h00);
  c_rate_change: cover property (st_ff.cause[`CB_RATE]);
endmodule : spdif_rx_status_interrupt
`default_nettype wire

// ---- tb/spdif_irq_host.sv ----
// host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module spdif_irq_host (
  input wire logic clk,
  output spdif_irq_pkg::reg_addr_t reg_addr,
  output logic reg_wr,
  output logic [8:0] reg_wdata,
  output logic reg_rd,
  input wire logic [8:0] reg_rdata
);
  initial
  begin
    reg_addr = 7'h7f;
    reg_wr = 1'b0;
    reg_wdata = 9'h000;
    reg_rd = 1'b0;
  end
  // idle address and data are inverted so a stale value is never mistaken for live
  task automatic wr(input spdif_irq_pkg::reg_addr_t a, input logic [8:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input spdif_irq_pkg::reg_addr_t a, output logic [8:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : spdif_irq_host
`default_nettype wire

// ---- tb/spdif_rx_status_interrupt_tb_top.sv ----
// self-checking bench for the status interrupt block
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_status_interrupt_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  spdif_irq_pkg::flag_vec_t fl = '0;
  spdif_irq_pkg::flag_vec_t old_fl;
  spdif_irq_pkg::reg_addr_t reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [8:0] reg_wdata;
  logic [8:0] reg_rdata;
  logic [8:0] rd_val;
  logic status_irq_low;
  spdif_irq_pkg::mask_t msk = '0;
  spdif_irq_pkg::cause_t carry = '0;
  spdif_irq_pkg::cause_t exp_c;
  int n_fail = 0;
  int checks_done = 0;
  integer seed = 32'h8d9f_aa0b;

  spdif_irq_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  spdif_rx_status_interrupt DUT (.clk(clk), .nrst(nrst), .lock_lost_flag(fl[0]),
    .invalid_flag(fl[1]), .chan_status_block_update(fl[2]), .frame_error_flag(fl[3]),
    .nonpcm_cs_flag(fl[4]), .burst_sync_flag(fl[5]), .copyright_free_flag(fl[6]),
    .preemphasis_flag(fl[7]), .recovered_rate_code(fl[9:8]), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_irq_low(status_irq_low));

  initial
  begin
    forever #10 clk = ~clk;
  end

  function automatic spdif_irq_pkg::cause_t ev(spdif_irq_pkg::flag_vec_t o,
    spdif_irq_pkg::flag_vec_t n, spdif_irq_pkg::mask_t m);
    spdif_irq_pkg::flag_vec_t d;
    spdif_irq_pkg::flag_vec_t r;
    d = o ^ n;
    r = ~o & n;
    ev[0] = d[0] & ~m[0];
    ev[1] = r[1] & ~m[1];
    ev[2] = r[2] & ~m[2];
    ev[3] = r[3] & ~m[3];
    ev[4] = (d[4] & ~m[4]) | (d[5] & ~m[5]);
    ev[5] = d[6] & ~m[6];
    ev[6] = d[7] & ~m[7];
    ev[7] = (|d[9:8]) & ~m[8];
  endfunction : ev

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk({8'h00, status_irq_low}, 9'h001);
    host.rd(7'h25, rd_val);
    chk(rd_val, 9'h000);
    host.wr(7'h2b, 9'h1ff);
    host.rd(7'h00, rd_val);
    chk(rd_val, 9'h000);
    host.rd(7'h2b, rd_val);
    chk(rd_val, 9'h000);
    // first two passes: everything masked, then unmasked falling edges
    for (int i = 0; i < 200; i++)
    begin
      msk = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : 9'($random(seed) & $random(seed));
      host.wr(7'h25, msk);
      old_fl = fl;
      fl = (i < 2) ? ~fl : fl ^ 10'($random(seed) & $random(seed));
      exp_c = carry | ev(old_fl, fl, msk);
      repeat (6) @(negedge clk);
      chk({8'h00, status_irq_low}, {8'h00, exp_c == 8'h00});
      host.rd(7'h31, rd_val);
      chk(rd_val, {2'b00, fl[0], fl[9:8], fl[7:4]});
      host.rd(7'h2b, rd_val);
      chk(rd_val, {1'b0, exp_c});
      carry = {4'h0, fl[3:1] & ~msk[3:1], 1'b0};
      host.rd(7'h2b, rd_val);
      chk(rd_val, {1'b0, carry});
      chk({8'h00, status_irq_low}, {8'h00, carry == 8'h00});
      host.rd(7'h25, rd_val);
      chk(rd_val, msk);
    end
    complete_run();
  end
endmodule : spdif_rx_status_interrupt_tb_top
`default_nettype wire
